// >>> rtl/aft_defs.vh
// constants for the api frame parser: framing bytes, frame types, register map, limits
// assumes inclusion by every rtl file of the block
`ifndef AFT_DEFS_VH
`define AFT_DEFS_VH
`define AFT_DELIM 8'h7E
`define AFT_ESC 8'h7D
`define AFT_ESC_XOR 8'h20
`define AFT_CSUM_GOOD 8'hFF
`define AFT_TYPE_TX16 8'h01
`define AFT_TYPE_ATCMD 8'h08
`define AFT_TYPE_TXSTAT 8'h89
`define AFT_TYPE_ATRSP 8'h88
`define AFT_BCAST_ADDR 16'hFFFF
`define AFT_OPT_NOACK 0
`define AFT_OPT_BCPAN 2
`define AFT_OPT_LEGAL 8'h05
`define AFT_TX16_MINLEN 16'h0005
`define AFT_ATCMD_MINLEN 16'h0004
`define AFT_TX16_HDR 16'h0005
`define AFT_ATCMD_HDR 16'h0004
`define AFT_NAME_ESC 16'h4150
`define AFT_NAME_MAXPL 16'h4E50
`define AFT_ESC_MODE_ON 2'h2
`define AFT_ESC_RESET 2'h1
`define AFT_RAM_AW 8
`define AFT_MAX_PAYLOAD 32'h0000_0100
`define AFT_REG_CTRL 9'h000
`define AFT_REG_STATUS 9'h001
`define AFT_REG_FINFO 9'h002
`define AFT_REG_DEST 9'h003
`define AFT_REG_PLEN 9'h004
`define AFT_REG_CMD 9'h005
`define AFT_REG_PARAM 9'h006
`define AFT_REG_DROPS 9'h007
`define AFT_ST_TXPEND 0
`define AFT_ST_CMDPEND 1
`define AFT_ST_CSUMERR 2
`define AFT_ST_FMTERR 3
`endif

// >>> rtl/aft_payload_ram.v
// payload store for one transmit frame, one write port and one registered read port
// assumes writer and reader share mclk; no reset on the array itself
`timescale 1ns/1ps
`include "aft_defs.vh"
module aft_payload_ram (
  input wire mclk,
  input wire wrEn,
  input wire [`AFT_RAM_AW-1:0] wrAddr,
  input wire [7:0] wrData,
  input wire [`AFT_RAM_AW-1:0] rdAddr,
  output reg [7:0] rdData
);
  reg [7:0] mem [0:(1<<`AFT_RAM_AW)-1];

  always @(posedge mclk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // aft_payload_ram

// >>> rtl/aft_esc_decoder.v
// removes escape sequences from the serial byte stream and flags frame delimiters
// assumes one byte per rxValid strobe, synchronous to mclk
`timescale 1ns/1ps
`include "aft_defs.vh"
module aft_esc_decoder (
  input wire mclk,
  input wire rst_n,
  input wire escEnable,
  input wire [7:0] rawData,
  input wire rawValid,
  output reg [7:0] outData,
  output reg outValid,
  output reg outDelim
);
  reg escPend_reg;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      escPend_reg <= 1'b0;
      outData <= 8'h00;
      outValid <= 1'b0;
      outDelim <= 1'b0;
    end
    else
    begin
      outValid <= 1'b0;
      outDelim <= 1'b0;
      if (rawValid)
      begin
        if (rawData == `AFT_DELIM)
        begin
          // a raw delimiter always restarts, even after a dangling escape
          escPend_reg <= 1'b0;
          outDelim <= 1'b1;
        end
        else if (escEnable && rawData == `AFT_ESC)
        begin
          escPend_reg <= 1'b1;
        end
        else
        begin
          outValid <= 1'b1;
          outData <= escPend_reg ? (rawData ^ `AFT_ESC_XOR) : rawData;
          escPend_reg <= 1'b0;
        end
      end
    end
  end
endmodule // aft_esc_decoder

// >>> rtl/aft_frame_engine.v
// api frame parser for 16-bit transmit requests and local command requests
// assumes serial bytes arrive one per rxValid strobe; registers on avalon-mm slave
// Contract
// - two bytes after delimiter count bytes between count field and checksum
// - type 0x01 frame requests transmit of payload to 16-bit address
// - frame id zero suppresses any response frame
// - bytes from position 5 hold destination; 0xFFFF means broadcast
// - options bit 0 no ack, bit 2 broadcast pan; other bits zero
// - payload from position 8 to checksum; max payload is queryable
// - checksum is 0xFF minus low byte of sum from position 3
// - nonzero-id transmit request gets status frame 0x89 with same id
// - type 0x08 sets or queries a setting, applied immediately
// - type 0x08 positions 5 and 6 hold two ascii command characters
// - value from position 7 sets; none means query current value
// - type 0x08 answered by 0x88 with id; query returns current value
// - frames start with 0x7E; delimiter and count excluded from checksum
// - frames with bad checksum are discarded entirely; here their payload bytes still overwrite the payload ram
// - escaped bytes arrive as 0x7D then byte xor 0x20
// - count excludes escapes; checksum over unescaped values
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`include "aft_defs.vh"
module aft_frame_engine (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] rxData,
  input wire rxValid,
  input wire txDone,
  input wire txSuccess,
  input wire [31:0] cfgQueryValue,
  output wire [15:0] cfgQueryName,
  output reg txReqStrobe,
  output reg txBroadcast,
  output reg [15:0] txDest,
  output reg [7:0] txOptions,
  output reg [7:0] txFrameId,
  output reg [15:0] txPayloadLen,
  output reg cmdStrobe,
  output reg cmdIsQuery,
  output reg [15:0] cmdName,
  output reg [31:0] cmdValue,
  output reg rspValid,
  output reg [7:0] rspType,
  output reg [7:0] rspFrameId,
  output reg [31:0] rspValue,
  output wire escEnable,
  input wire [8:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWritedata,
  output wire [31:0] avsReaddata,
  output wire avsWaitrequest
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_LENH = 5'b00010;
  localparam [4:0] ST_LENL = 5'b00100;
  localparam [4:0] ST_BODY = 5'b01000;
  localparam [4:0] ST_CSUM = 5'b10000;

  wire [7:0] byteData;
  wire byteValid;
  wire byteDelim;
  wire [7:0] ramRdData;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [15:0] len_reg;
  reg [15:0] pos_reg;
  reg [7:0] sum_reg;
  reg [7:0] curType_reg;
  reg [7:0] curId_reg;
  reg [15:0] curWord_reg;
  reg [7:0] curOpt_reg;
  reg [31:0] curParam_reg;
  reg [1:0] escSetting_reg;
  reg [3:0] status_reg;
  reg [3:0] status_next;
  reg [15:0] drops_reg;
  reg [7:0] pendId_reg;
  reg txStatPend_reg;
  reg txStatFail_reg;
  reg rdDone_reg;
  reg [31:0] rdHold_reg;
  reg rdRam_reg;

  aft_esc_decoder i_aft_esc_decoder (
    .mclk(mclk),
    .rst_n(rst_n),
    .escEnable(escEnable),
    .rawData(rxData),
    .rawValid(rxValid),
    .outData(byteData),
    .outValid(byteValid),
    .outDelim(byteDelim)
  );

  // payload address is the body position less the fixed fields
  wire [15:0] plIndex = pos_reg - `AFT_TX16_HDR;
  wire ramWr = state_reg[3] && byteValid && curType_reg == `AFT_TYPE_TX16 &&
    pos_reg >= `AFT_TX16_HDR && plIndex < `AFT_MAX_PAYLOAD;

  aft_payload_ram i_aft_payload_ram (
    .mclk(mclk),
    .wrEn(ramWr),
    .wrAddr(plIndex[`AFT_RAM_AW-1:0]),
    .wrData(byteData),
    .rdAddr(avsAddress[`AFT_RAM_AW-1:0]),
    .rdData(ramRdData)
  );

  assign escEnable = (escSetting_reg == `AFT_ESC_MODE_ON);
  assign cfgQueryName = curWord_reg;

  // frame decode at the checksum byte
  wire csumByte = state_reg[4] && byteValid;
  wire csumOk = (sum_reg + byteData) == `AFT_CSUM_GOOD;
  wire isTx = curType_reg == `AFT_TYPE_TX16;
  wire isCmd = curType_reg == `AFT_TYPE_ATCMD;
  wire txLenOk = len_reg >= `AFT_TX16_MINLEN &&
    {16'h0000, len_reg - `AFT_TX16_HDR} <= `AFT_MAX_PAYLOAD;
  wire cmdLenOk = len_reg >= `AFT_ATCMD_MINLEN;
  wire optOk = (curOpt_reg & ~`AFT_OPT_LEGAL) == 8'h00;
  wire txGood = csumByte && csumOk && isTx && txLenOk && optOk;
  wire cmdGood = csumByte && csumOk && isCmd && cmdLenOk;
  wire fmtBad = csumByte && csumOk && ((isTx && !(txLenOk && optOk)) || (isCmd && !cmdLenOk));
  wire cmdQuery = len_reg == `AFT_ATCMD_HDR;
  wire cmdRsp = cmdGood && curId_reg != 8'h00;

  // the current value of a setting this block owns is answered locally
  reg [31:0] queryVal;
  always @*
  begin
    queryVal = cfgQueryValue;
    if (curWord_reg == `AFT_NAME_ESC)
    begin
      queryVal = {30'h0000_0000, escSetting_reg};
    end
    else if (curWord_reg == `AFT_NAME_MAXPL)
    begin
      queryVal = `AFT_MAX_PAYLOAD;
    end
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_LENH: if (byteValid) state_next = ST_LENL;
      ST_LENL: if (byteValid) state_next = ({len_reg[15:8], byteData} == 16'h0000) ? ST_CSUM : ST_BODY;
      ST_BODY: if (byteValid && pos_reg == len_reg - 16'h0001) state_next = ST_CSUM;
      ST_CSUM: if (byteValid) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (byteDelim)
    begin
      state_next = ST_LENH;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      len_reg <= 16'h0000;
      pos_reg <= 16'h0000;
      sum_reg <= 8'h00;
      curType_reg <= 8'h00;
      curId_reg <= 8'h00;
      curWord_reg <= 16'h0000;
      curOpt_reg <= 8'h00;
      curParam_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      if (byteDelim)
      begin
        // a restart drops whatever partial frame was collected
        pos_reg <= 16'h0000;
        sum_reg <= 8'h00;
        curType_reg <= 8'h00;
        curOpt_reg <= 8'h00;
        curParam_reg <= 32'h0000_0000;
      end
      else if (byteValid)
      begin
        if (state_reg[1])
        begin
          len_reg <= {byteData, 8'h00};
        end
        if (state_reg[2])
        begin
          len_reg <= {len_reg[15:8], byteData};
        end
        if (state_reg[3])
        begin
          pos_reg <= pos_reg + 16'h0001;
          sum_reg <= sum_reg + byteData;
          if (pos_reg == 16'h0000)
          begin
            curType_reg <= byteData;
          end
          if (pos_reg == 16'h0001)
          begin
            curId_reg <= byteData;
          end
          if (pos_reg == 16'h0002 || pos_reg == 16'h0003)
          begin
            curWord_reg <= {curWord_reg[7:0], byteData};
          end
          if (pos_reg == 16'h0004 && isTx)
          begin
            curOpt_reg <= byteData;
          end
          if (pos_reg >= `AFT_ATCMD_HDR && pos_reg < 16'h0008 && isCmd)
          begin
            curParam_reg <= {curParam_reg[23:0], byteData};
          end
        end
      end
    end
  end

  // events from decoded serial frames and from software that touch the sticky status
  wire wrStatus = avsWrite && avsAddress == `AFT_REG_STATUS;
  always @*
  begin
    status_next = status_reg & ~(wrStatus ? avsWritedata[3:0] : 4'h0);
    // a set in the same cycle as the clear wins
    if (txGood)
    begin
      status_next[`AFT_ST_TXPEND] = 1'b1;
    end
    if (cmdGood)
    begin
      status_next[`AFT_ST_CMDPEND] = 1'b1;
    end
    if (csumByte && !csumOk)
    begin
      status_next[`AFT_ST_CSUMERR] = 1'b1;
    end
    if (fmtBad)
    begin
      status_next[`AFT_ST_FMTERR] = 1'b1;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_reg <= 4'h0;
      drops_reg <= 16'h0000;
      escSetting_reg <= `AFT_ESC_RESET;
      txReqStrobe <= 1'b0;
      txBroadcast <= 1'b0;
      txDest <= 16'h0000;
      txOptions <= 8'h00;
      txFrameId <= 8'h00;
      txPayloadLen <= 16'h0000;
      cmdStrobe <= 1'b0;
      cmdIsQuery <= 1'b0;
      cmdName <= 16'h0000;
      cmdValue <= 32'h0000_0000;
      pendId_reg <= 8'h00;
      txStatPend_reg <= 1'b0;
      txStatFail_reg <= 1'b0;
      rspValid <= 1'b0;
      rspType <= 8'h00;
      rspFrameId <= 8'h00;
      rspValue <= 32'h0000_0000;
    end
    else
    begin
      status_reg <= status_next;
      txReqStrobe <= txGood;
      cmdStrobe <= cmdGood;
      rspValid <= 1'b0;
      if ((csumByte && !csumOk) || fmtBad)
      begin
        drops_reg <= drops_reg + 16'h0001;
      end
      if (avsWrite && avsAddress == `AFT_REG_CTRL)
      begin
        escSetting_reg <= avsWritedata[1:0];
      end
      if (txGood)
      begin
        txDest <= curWord_reg;
        txBroadcast <= curWord_reg == `AFT_BCAST_ADDR;
        txOptions <= curOpt_reg & `AFT_OPT_LEGAL;
        txFrameId <= curId_reg;
        txPayloadLen <= len_reg - `AFT_TX16_HDR;
        pendId_reg <= curId_reg;
      end
      if (cmdGood)
      begin
        cmdName <= curWord_reg;
        cmdIsQuery <= cmdQuery;
        cmdValue <= curParam_reg;
        if (!cmdQuery && curWord_reg == `AFT_NAME_ESC)
        begin
          escSetting_reg <= curParam_reg[1:0];
        end
      end
      // only the latest transmit id is tracked; status for id zero is never queued
      if (txDone && pendId_reg != 8'h00)
      begin
        txStatPend_reg <= 1'b1;
        txStatFail_reg <= !txSuccess;
      end
      if (cmdRsp)
      begin
        rspValid <= 1'b1;
        rspType <= `AFT_TYPE_ATRSP;
        rspFrameId <= curId_reg;
        rspValue <= cmdQuery ? queryVal : 32'h0000_0000;
      end
      else if (txStatPend_reg)
      begin
        // command answers take the slot; the status goes out one cycle later
        rspValid <= 1'b1;
        rspType <= `AFT_TYPE_TXSTAT;
        rspFrameId <= pendId_reg;
        rspValue <= {31'h0000_0000, txStatFail_reg};
        txStatPend_reg <= txDone && pendId_reg != 8'h00;
      end
    end
  end

  // bus reads take two cycles so ram and register data both come from flops
  assign avsWaitrequest = avsRead && !rdDone_reg;
  assign avsReaddata = rdRam_reg ? {24'h00_0000, ramRdData} : rdHold_reg;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdDone_reg <= 1'b0;
      rdRam_reg <= 1'b0;
      rdHold_reg <= 32'h0000_0000;
    end
    else
    begin
      rdDone_reg <= avsRead && !rdDone_reg;
      if (avsRead && !rdDone_reg)
      begin
        rdRam_reg <= avsAddress[8];
        case (avsAddress)
          `AFT_REG_CTRL: rdHold_reg <= {30'h0000_0000, escSetting_reg};
          `AFT_REG_STATUS: rdHold_reg <= {28'h000_0000, status_reg};
          `AFT_REG_FINFO: rdHold_reg <= {8'h00, txOptions, txFrameId, 7'h00, txBroadcast};
          `AFT_REG_DEST: rdHold_reg <= {16'h0000, txDest};
          `AFT_REG_PLEN: rdHold_reg <= {16'h0000, txPayloadLen};
          `AFT_REG_CMD: rdHold_reg <= {15'h0000, cmdIsQuery, cmdName};
          `AFT_REG_PARAM: rdHold_reg <= cmdValue;
          `AFT_REG_DROPS: rdHold_reg <= {16'h0000, drops_reg};
          default: rdHold_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // aft_frame_engine

// >>> verification/aft_frame_engine_properties.sv
// port assertions for the frame engine
// assumes a bind onto aft_frame_engine
`timescale 1ns/1ps
`include "aft_defs.vh"
module aft_frame_engine_properties (
  input wire mclk,
  input wire rst_n,
  input wire txDone,
  input wire txReqStrobe,
  input wire txBroadcast,
  input wire [15:0] txDest,
  input wire [7:0] txOptions,
  input wire cmdStrobe,
  input wire cmdIsQuery,
  input wire rspValid,
  input wire [7:0] rspType,
  input wire [7:0] rspFrameId,
  input wire [31:0] rspValue,
  input wire avsRead,
  input wire avsWaitrequest
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence rdAsk;
    avsRead && avsWaitrequest;
  endsequence
  sequence rdGive;
    avsRead && !avsWaitrequest;
  endsequence
  tx_pulse_a: assert property (txReqStrobe |=> !txReqStrobe)
    else $error("tx strobe too long");
  cmd_pulse_a: assert property (cmdStrobe |=> !cmdStrobe)
    else $error("cmd strobe too long");
  bcast_flag_a: assert property (txReqStrobe |-> txBroadcast == (txDest == 16'hFFFF))
    else $error("broadcast flag wrong");
  opt_mask_a: assert property (txReqStrobe |-> (txOptions & 8'hFA) == 8'h00)
    else $error("reserved option bit passed");
  rsp_id_a: assert property (rspValid |-> rspFrameId != 8'h00)
    else $error("response for id zero");
  cmd_rsp_a: assert property (rspValid && rspType == 8'h88 |-> cmdStrobe)
    else $error("command response without command");
  // a status answer may share the cycle of an id-zero command, so the type is part of the test
  set_rsp_a: assert property (cmdStrobe && !cmdIsQuery && rspValid && rspType == 8'h88 |->
    rspValue == 32'h0000_0000)
    else $error("set response value wrong");
  // two cycles after the completion pulse, three when a command answer took the slot
  stat_cause_a: assert property (rspValid && rspType == 8'h89 |->
    ($past(txDone, 2) || $past(txDone, 3)) && rspValue[31:1] == 31'h0000_0000)
    else $error("status without radio completion");
  rd_wait_a: assert property (rdAsk |=> rdGive)
    else $error("read wait not one cycle");
endmodule // aft_frame_engine_properties
bind aft_frame_engine aft_frame_engine_properties i_aft_frame_engine_properties (
  .mclk(mclk), .rst_n(rst_n), .txDone(txDone), .txReqStrobe(txReqStrobe),
  .txBroadcast(txBroadcast), .txDest(txDest), .txOptions(txOptions),
  .cmdStrobe(cmdStrobe), .cmdIsQuery(cmdIsQuery), .rspValid(rspValid),
  .rspType(rspType), .rspFrameId(rspFrameId), .rspValue(rspValue),
  .avsRead(avsRead), .avsWaitrequest(avsWaitrequest));

// >>> verification/aft_host_model.sv
// host model: frames bytes onto the serial input and pulses radio completion
// assumes the engine takes rxData on rising mclk while rxValid is high
`timescale 1ns/1ps
`include "aft_defs.vh"
module aft_host_model (
  input wire mclk,
  input wire escEnable,
  output logic [7:0] rxData = 8'h00,
  output logic rxValid = 1'b0,
  output logic txDone = 1'b0,
  output logic txSuccess = 1'b0
);
  logic [7:0] lastByte = 8'h00;
  task put(input logic [7:0] b);
    @(posedge mclk);
    rxData <= b;
    rxValid <= 1'b1;
    lastByte = b;
  endtask
  task put_esc(input logic [7:0] b);
    if (escEnable && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13))
    begin
      put(`AFT_ESC);
      put(b ^ `AFT_ESC_XOR);
    end
    else
      put(b);
  endtask
  // bad is added to the checksum to corrupt it on purpose
  // legacy 16-bit transmit frames are sent only for compatibility
  // settings go out as immediate requests, never through the queued type
  task send(input logic [7:0] body[$], input logic [7:0] bad);
    logic [7:0] sum;
    logic [15:0] len;
    sum = 8'h00;
    len = 16'(body.size());
    put(`AFT_DELIM);
    put_esc(len[15:8]);
    put_esc(len[7:0]);
    foreach (body[i])
    begin
      sum = sum + body[i];
      put_esc(body[i]);
    end
    put_esc(8'hFF - sum + bad);
    @(posedge mclk);
    rxValid <= 1'b0;
    // idle line shows no stale byte
    rxData <= ~lastByte;
  endtask
  task radio_done(input logic ok);
    @(posedge mclk);
    txDone <= 1'b1;
    txSuccess <= ok;
    @(posedge mclk);
    txDone <= 1'b0;
    txSuccess <= ~ok;
  endtask
endmodule // aft_host_model

// >>> verification/api_frame_tx_and_at_request_bench.sv
// bench for the frame engine: serial frames, radio status, avalon registers
// assumes aft_host_model on the serial side and the checker bound in
`timescale 1ns/1ps
`include "aft_defs.vh"
module api_frame_tx_and_at_request_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [8:0] avsAddress = 9'h000;
  logic [31:0] avsWritedata = 32'h0, cfgQueryValue = 32'h0000_1234;
  logic [31:0] rd, d0, rspV;
  logic [7:0] rspT, rspI;
  wire [7:0] rxData, txOptions, txFrameId, rspType, rspFrameId;
  wire [15:0] cfgQueryName, txDest, txPayloadLen, cmdName;
  wire [31:0] cmdValue, rspValue, avsReaddata;
  wire rxValid, txDone, txSuccess, txReqStrobe, txBroadcast, cmdStrobe, cmdIsQuery;
  wire rspValid, escEnable, avsWaitrequest;
  integer n_errors = 0, num_checks = 0, nTx = 0, nCmd = 0, nRsp = 0;
  aft_frame_engine i_aft_frame_engine (.mclk(mclk), .rst_n(rst_n), .rxData(rxData),
    .rxValid(rxValid), .txDone(txDone), .txSuccess(txSuccess),
    .cfgQueryValue(cfgQueryValue), .cfgQueryName(cfgQueryName), .txReqStrobe(txReqStrobe),
    .txBroadcast(txBroadcast), .txDest(txDest), .txOptions(txOptions),
    .txFrameId(txFrameId), .txPayloadLen(txPayloadLen), .cmdStrobe(cmdStrobe),
    .cmdIsQuery(cmdIsQuery), .cmdName(cmdName), .cmdValue(cmdValue), .rspValid(rspValid),
    .rspType(rspType), .rspFrameId(rspFrameId), .rspValue(rspValue), .escEnable(escEnable),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest));
  aft_host_model i_aft_host_model (.mclk(mclk), .escEnable(escEnable), .rxData(rxData),
    .rxValid(rxValid), .txDone(txDone), .txSuccess(txSuccess));
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (txReqStrobe === 1'b1) nTx <= nTx + 1;
    if (cmdStrobe === 1'b1) nCmd <= nCmd + 1;
    if (rspValid === 1'b1)
    begin
      nRsp <= nRsp + 1;
      rspT <= rspType;
      rspI <= rspFrameId;
      rspV <= rspValue;
    end
  end
  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (avsWaitrequest !== 1'b0 && k < 20);
    rd = avsReaddata;
    if (k >= 20)
    begin
      n_errors++;
      close_out;
    end
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task rchk(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check("register", rd, exp);
  endtask
  task settle;
    repeat (6) @(posedge mclk);
  endtask
  task rsp(input logic [7:0] t, input logic [7:0] id, input logic [31:0] v);
    check("rsp type", rspT, t);
    check("rsp id", rspI, id);
    check("rsp value", rspV, v);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(`AFT_REG_CTRL, 32'h0000_0001);
    rchk(`AFT_REG_STATUS, 32'h0000_0000);
    rchk(9'h010, 32'h0000_0000);
    $display("test reset done");
    i_aft_host_model.put(8'h7E);
    i_aft_host_model.put(8'h00);
    i_aft_host_model.send('{8'h01, 8'h87, 8'h12, 8'h34, 8'h00, 8'h54, 8'h78, 8'h44,
      8'h61, 8'h74, 8'h61}, 8'h00);
    settle;
    check("tx count", nTx, 1);
    check("dest", txDest, 16'h1234);
    check("id", txFrameId, 8'h87);
    check("plen", txPayloadLen, 16'h0006);
    rchk(9'h105, 32'h0000_0061);
    rchk(`AFT_REG_FINFO, 32'h0000_8700);
    i_aft_host_model.radio_done(1'b0);
    settle;
    check("rsp count", nRsp, 1);
    rsp(8'h89, 8'h87, 32'h0000_0001);
    i_aft_host_model.send('{8'h01, 8'h00, 8'hFF, 8'hFF, 8'h05, 8'h42}, 8'h00);
    i_aft_host_model.radio_done(1'b1);
    settle;
    check("bcast", txBroadcast, 1'b1);
    check("options", txOptions, 8'h05);
    check("rsp count", nRsp, 1);
    rchk(`AFT_REG_DEST, 32'h0000_FFFF);
    $display("test transmit done");
    bus(1'b1, `AFT_REG_STATUS, 32'h0000_000F);
    bus(1'b0, `AFT_REG_DROPS, 32'h0000_0000);
    d0 = rd;
    i_aft_host_model.send('{8'h01, 8'h87, 8'h12, 8'h34, 8'h00, 8'h54}, 8'h01);
    settle;
    rchk(`AFT_REG_STATUS, 32'h0000_0004);
    rchk(`AFT_REG_DROPS, d0 + 1);
    bus(1'b1, `AFT_REG_STATUS, 32'h0000_000F);
    i_aft_host_model.send('{8'h01, 8'h05, 8'h12, 8'h34, 8'h02, 8'hAA}, 8'h00);
    settle;
    rchk(`AFT_REG_STATUS, 32'h0000_0008);
    i_aft_host_model.send('{8'h01, 8'h05, 8'h12, 8'h34}, 8'h00);
    i_aft_host_model.send('{8'h08, 8'h05, 8'h41}, 8'h00);
    settle;
    rchk(`AFT_REG_DROPS, d0 + 4);
    check("tx count", nTx, 2);
    $display("test refusal done");
    i_aft_host_model.send('{8'h08, 8'h17, 8'h54, 8'h50}, 8'h00);
    settle;
    check("query", cmdIsQuery, 1'b1);
    check("name", cmdName, 16'h5450);
    check("query name", cfgQueryName, 16'h5450);
    rchk(`AFT_REG_CMD, 32'h0001_5450);
    rsp(8'h88, 8'h17, 32'h0000_1234);
    i_aft_host_model.send('{8'h08, 8'h18, 8'h4E, 8'h50}, 8'h00);
    settle;
    rsp(8'h88, 8'h18, 32'h0000_0100);
    i_aft_host_model.send('{8'h08, 8'h19, 8'h41, 8'h50, 8'h02}, 8'h00);
    settle;
    rsp(8'h88, 8'h19, 32'h0000_0000);
    check("value", cmdValue, 32'h0000_0002);
    rchk(`AFT_REG_PARAM, 32'h0000_0002);
    check("esc", escEnable, 1'b1);
    check("cmd count", nCmd, 3);
    $display("test command done");
    i_aft_host_model.send('{8'h01, 8'h22, 8'h7E, 8'h11, 8'h00, 8'h7D, 8'h13}, 8'h00);
    settle;
    check("dest", txDest, 16'h7E11);
    check("plen", txPayloadLen, 16'h0002);
    rchk(9'h100, 32'h0000_007D);
    i_aft_host_model.radio_done(1'b1);
    settle;
    check("rsp count", nRsp, 5);
    rsp(8'h89, 8'h22, 32'h0000_0000);
    $display("test escape done");
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(`AFT_REG_CTRL, 32'h0000_0001);
    check("esc off", escEnable, 1'b0);
    bus(1'b1, `AFT_REG_CTRL, 32'h0000_0002);
    rchk(`AFT_REG_CTRL, 32'h0000_0002);
    check("esc on", escEnable, 1'b1);
    bus(1'b1, `AFT_REG_CTRL, 32'h0000_0001);
    rchk(`AFT_REG_CTRL, 32'h0000_0001);
    $display("test second reset done");
    close_out;
  end
  initial
  begin
    repeat (50000) @(posedge mclk);
    n_errors++;
    close_out;
  end
endmodule // api_frame_tx_and_at_request_bench
